// ---- hw/port_svc_regs.svh ----
`ifndef PORT_SVC_REGS_SVH
`define PORT_SVC_REGS_SVH
// Functional notes
// - per-pin sticky flag plus live level bit
// - source qualified by flag, enable, no DMA
// - irq is OR of four, when selected
// - DMA pulses keep buffers full or empty
// - acknowledge drives vector of best source
// - vector upper six from register, low two priority
// - acknowledge changes no internal state
// - no function or no irq: ignore acknowledge
// - unwritten vector register returns fixed value
// - third source 10, fourth source 11
// - autovector mode supplies no vector
// - bus DMA request three clocks after select
// - peripheral DMA request after handshake, three long
// - handshakes sync rising, select sync falling
// - edge input sets status flag
// - mask write clears resettable flags only
// - four sense bits invert pins, reset low
// - disabled port holds controller empty
// - disabled port holds simple flags cleared
// - disabled port holds second output negated
// - alternate registers show live pin levels
`define UNINIT_VECTOR   8'h0f
`define DMA_BUS_DELAY   3
`define DMA_HS_DELAY    2
`define DMA_PULSE_LEN   3
`define VEC_SRC_1       2'h0
`define VEC_SRC_2       2'h1
`define VEC_SRC_3       2'h2
`define VEC_SRC_4       2'h3
`endif

// ---- hw/port_svc_pkg.sv ----
package port_svc_pkg;
  typedef struct packed {
    logic [3:0] status;
    logic [3:0] level;
  } hs_state_t;
  typedef enum logic [1:0] {
    IRQ_NONE = 2'b00,
    IRQ_VEC  = 2'b01,
    IRQ_AUTO = 2'b10
  } irq_fn_t;
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_WAIT = 2'b01,
    DMA_HOLD = 2'b10
  } dma_st_t;
endpackage : port_svc_pkg

// ---- hw/port_service_request_logic.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "port_svc_regs.svh"
module port_service_request_logic (
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  input  wire logic [3:0]              hs_pin_i,
  input  wire logic [3:0]              sense_i,
  input  wire logic                    port_a_hs_enable_i,
  input  wire logic                    port_b_hs_enable_i,
  input  wire logic [3:0]              svc_enable_i,
  input  wire logic [1:0]              dma_assoc_i,
  input  wire logic [3:0]              edge_mode_i,
  input  wire logic [3:0]              direct_reset_i,
  input  wire port_svc_pkg::irq_fn_t   irq_fn_i,
  input  wire logic                    status_wr_i,
  input  wire logic [7:0]              status_wdata_i,
  input  wire logic [3:0]              buf_status_i,
  input  wire logic [1:0]              buf_out_ready_i,
  input  wire logic                    vector_wr_i,
  input  wire logic [7:2]              vector_wdata_i,
  input  wire logic                    port_irq_ack_in_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    dma_bus_cond_i,
  input  wire logic                    dma_hs_cond_i,
  input  wire logic [7:0]              port_a_pins_i,
  input  wire logic [7:0]              port_b_pins_i,
  output port_svc_pkg::hs_state_t      hs_state_o,
  output logic                         port_irq_out_o,
  output logic [7:0]                   vector_o,
  output logic                         vector_oe_o,
  output logic                         transfer_ack_out_o,
  output logic                         dma_req_out_o,
  output logic [1:0]                   hs_out_o,
  output logic [1:0]                   hold_empty_o,
  output logic [7:0]                   port_a_alt_o,
  output logic [7:0]                   port_b_alt_o
);
  import port_svc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] hs_sync;
  logic [3:0] hs_prev;
  logic [3:0] hs_asserted;
  logic [3:0] flags;
  logic [3:0] port_en;
  logic [5:0] port_vector_reg;
  logic       vector_written;
  logic [3:0] qualified;
  logic       cs_sync_n;
  logic       cs_prev_n;
  dma_st_t    dma_st;
  logic [1:0] dma_cnt;
  logic       hs_half;
  logic [1:0] next_prio;

  function automatic logic [1:0] prio_encode(input logic [3:0] req);
    if (req[0])
      prio_encode = `VEC_SRC_1;
    else if (req[1])
      prio_encode = `VEC_SRC_2;
    else if (req[2])
      prio_encode = `VEC_SRC_3;
    else
      prio_encode = `VEC_SRC_4;
  endfunction : prio_encode

  assign port_en = {port_b_hs_enable_i, port_b_hs_enable_i,
                    port_a_hs_enable_i, port_a_hs_enable_i};
  // inverted sense bits xor pins; zero means active low
  assign hs_asserted = hs_sync ^ ~sense_i;

  ////////////////////////////////////////////////////////////////////////
  // handshake synchroniser, rising edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hs_sync <= 4'h0;
      // seen as asserted: no false edge after reset
      hs_prev <= 4'hf;
    end else begin
      hs_sync <= hs_pin_i;
      hs_prev <= hs_asserted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!port_en[i] && edge_mode_i[i])
          flags[i] <= 1'b0;
        else if (edge_mode_i[i] && hs_asserted[i] && !hs_prev[i])
          flags[i] <= 1'b1;
        else if (status_wr_i && status_wdata_i[i] && direct_reset_i[i])
          flags[i] <= 1'b0;
      end
    end
  end

  always_comb begin
    hs_state_o.level = hs_asserted;
    for (int i = 0; i < 4; i++)
      hs_state_o.status[i] = edge_mode_i[i] ? flags[i] : buf_status_i[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request
  always_comb begin
    qualified = hs_state_o.status & svc_enable_i;
    qualified[0] = qualified[0] & ~dma_assoc_i[0];
    qualified[2] = qualified[2] & ~dma_assoc_i[1];
  end

  assign port_irq_out_o = (irq_fn_i != IRQ_NONE) && (|qualified);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_vector_reg <= 6'h00;
      vector_written  <= 1'b0;
    end else if (vector_wr_i) begin
      port_vector_reg <= vector_wdata_i;
      vector_written  <= 1'b1;
    end
  end

  // acknowledge path is read-only: nothing is stored here
  assign next_prio = prio_encode(qualified);
  assign transfer_ack_out_o = port_irq_ack_in_i && port_irq_out_o;
  assign vector_oe_o = transfer_ack_out_o && (irq_fn_i == IRQ_VEC);

  always_ff @(posedge clk_i) begin
    if (srst_i)
      vector_o <= 8'h00;
    else if (!vector_written)
      vector_o <= `UNINIT_VECTOR;
    else
      vector_o <= {port_vector_reg, next_prio};
  end

  ////////////////////////////////////////////////////////////////////////
  // chip select synchroniser, falling edge
  always_ff @(negedge clk_i) begin
    if (srst_i) begin
      cs_sync_n <= 1'b1;
      cs_prev_n <= 1'b1;
    end else begin
      cs_sync_n <= cs_n_i;
      cs_prev_n <= cs_sync_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma request pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dma_st  <= DMA_IDLE;
      dma_cnt <= 2'h0;
      hs_half <= 1'b0;
    end else begin
      unique case (dma_st)
        DMA_IDLE: begin
          if (dma_bus_cond_i && !cs_sync_n && cs_prev_n) begin
            dma_st  <= DMA_WAIT;
            dma_cnt <= 2'(`DMA_BUS_DELAY - 1);
          end else if (dma_hs_cond_i &&
                       |(hs_asserted[2:0] & ~hs_prev[2:0] & 3'b101)) begin
            dma_st  <= DMA_WAIT;
            dma_cnt <= 2'(`DMA_HS_DELAY - 1);
          end
        end
        DMA_WAIT: begin
          if (dma_cnt == 2'h0) begin
            dma_st  <= DMA_HOLD;
            dma_cnt <= 2'(`DMA_PULSE_LEN - 1);
          end else
            dma_cnt <= dma_cnt - 2'h1;
        end
        DMA_HOLD: begin
          if (dma_cnt == 2'h0)
            dma_st <= DMA_IDLE;
          else
            dma_cnt <= dma_cnt - 2'h1;
        end
        default: dma_st <= DMA_IDLE;
      endcase
    end
  end

  assign dma_req_out_o = (dma_st == DMA_HOLD);

  ////////////////////////////////////////////////////////////////////////
  // port enables and outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hs_out_o     <= 2'b00;
      hold_empty_o <= 2'b11;
    end else begin
      hold_empty_o <= ~{port_b_hs_enable_i, port_a_hs_enable_i};
      hs_out_o[0] <= port_a_hs_enable_i && buf_out_ready_i[0];
      hs_out_o[1] <= port_b_hs_enable_i && buf_out_ready_i[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_a_alt_o <= 8'h00;
      port_b_alt_o <= 8'h00;
    end else begin
      port_a_alt_o <= port_a_pins_i;
      port_b_alt_o <= port_b_pins_i;
    end
  end
endmodule : port_service_request_logic
`default_nettype wire

// ---- tb/irq_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic go_i,
  output var  logic ack_o
);
  // acknowledge follows the host's own cycle request
  always_ff @(posedge clk_i) begin
    if (srst_i) ack_o <= 1'b0;
    else ack_o <= go_i;
  end
endmodule : irq_host_model
`default_nettype wire

// ---- tb/port_svc_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module port_svc_monitor
  import port_svc_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      srst_i,
  input wire logic      port_a_hs_enable_i,
  input wire logic [3:0] svc_enable_i,
  input wire logic [3:0] edge_mode_i,
  input wire logic [1:0] dma_assoc_i,
  input wire irq_fn_t   irq_fn_i,
  input wire logic      port_irq_ack_in_i,
  input wire hs_state_t hs_state_o,
  input wire logic      port_irq_out_o,
  input wire logic      vector_oe_o,
  input wire logic      transfer_ack_out_o,
  input wire logic      dma_req_out_o,
  input wire logic [1:0] hs_out_o,
  input wire logic [1:0] hold_empty_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [3:0] q;
  assign q = svc_enable_i & ~{1'b0, dma_assoc_i[1], 1'b0, dma_assoc_i[0]};
  a_irq_or_terms: assert property (port_irq_out_o ==
    (irq_fn_i != IRQ_NONE && |(hs_state_o.status & q))) else $error("irq");
  a_ack_refused: assert property (!port_irq_out_o |->
    !transfer_ack_out_o && !vector_oe_o) else $error("ack refused");
  a_ack_given: assert property (port_irq_ack_in_i &&
    port_irq_out_o |-> transfer_ack_out_o) else $error("ack given");
  a_auto_no_vec: assert property (irq_fn_i == IRQ_AUTO |->
    !vector_oe_o) else $error("auto vector");
  a_vec_drive: assert property (vector_oe_o |-> irq_fn_i == IRQ_VEC
    && port_irq_ack_in_i) else $error("vector drive");
  a_dma_three: assert property ($rose(dma_req_out_o) |->
    dma_req_out_o[*3] ##1 !dma_req_out_o) else $error("dma length");
  a_off_flags: assert property (!port_a_hs_enable_i ##1
    !port_a_hs_enable_i |-> (hs_state_o.status[1:0] & edge_mode_i[1:0])
    == 2'h0) else $error("flags while off");
  a_off_output: assert property (!port_a_hs_enable_i ##1
    !port_a_hs_enable_i |-> !hs_out_o[0] && hold_empty_o[0])
    else $error("outputs while off");
endmodule : port_svc_monitor
bind port_service_request_logic port_svc_monitor mon (.clk_i, .srst_i,
  .port_a_hs_enable_i, .svc_enable_i, .edge_mode_i, .dma_assoc_i,
  .irq_fn_i, .port_irq_ack_in_i, .hs_state_o, .port_irq_out_o,
  .vector_oe_o, .transfer_ack_out_o, .dma_req_out_o, .hs_out_o,
  .hold_empty_o);
`default_nettype wire

// ---- tb/port_service_request_logic_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module port_service_request_logic_tb;
  import port_svc_pkg::*;
  logic clk_i, srst_i, ea, eb, wr, vw, cs_n, go, ack, dc, irq, xa, dma, oe;
  logic [3:0] pin, sen, svc;
  logic [1:0] asc, hso, he;
  logic [7:0] md, vec, pa, alta, altb;
  irq_fn_t fn;
  hs_state_t hs;
  int bad_count, num_checks, cyc, i;
  port_service_request_logic dut (.clk_i, .srst_i, .hs_pin_i(pin),
    .sense_i(sen), .port_a_hs_enable_i(ea), .port_b_hs_enable_i(eb),
    .svc_enable_i(svc), .dma_assoc_i(asc), .edge_mode_i(4'hf),
    .direct_reset_i(4'hf), .irq_fn_i(fn), .status_wr_i(wr),
    .status_wdata_i(md), .buf_status_i(4'h0), .buf_out_ready_i(2'h3),
    .vector_wr_i(vw), .vector_wdata_i(6'h2a), .port_irq_ack_in_i(ack),
    .cs_n_i(cs_n), .dma_bus_cond_i(dc), .dma_hs_cond_i(dc),
    .port_a_pins_i(pa), .port_b_pins_i(~pa), .hs_state_o(hs),
    .port_irq_out_o(irq), .vector_o(vec), .vector_oe_o(oe),
    .transfer_ack_out_o(xa), .dma_req_out_o(dma), .hs_out_o(hso),
    .hold_empty_o(he), .port_a_alt_o(alta), .port_b_alt_o(altb));
  irq_host_model host (.clk_i, .srst_i, .go_i(go), .ack_o(ack));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  // latency and width of one request pulse, bus or pin side
  task automatic dl(input logic bus);
    int n;
    n = 0;
    @(posedge clk_i);
    if (bus) cs_n <= 1'b0;
    else pin[0] <= 1'b0;
    while (dma !== 1'b1 && n < 9) begin
      tk(1);
      n++;
    end
    chk("delay", n[7:0], 8'h04);
    n = 0;
    while (dma === 1'b1 && n < 9) begin
      tk(1);
      n++;
    end
    chk("width", n[7:0], 8'h03);
    @(posedge clk_i) cs_n <= 1'b1;
    pin[0] <= 1'b1;
    tk(4);
  endtask : dl
  initial begin
    srst_i = 1'b1;
    {ea, eb, wr, vw, go, dc, cs_n} = 7'h01;
    {pin, sen, svc, asc, md} = {4'hf, 4'h0, 4'hf, 2'h0, 8'h00};
    pa = 8'h5a;
    fn = IRQ_VEC;
    tk(2);
    chk("reset", {hs.status, irq, dma, hso}, 8'h00);
    @(posedge clk_i) srst_i <= 1'b0;
    pin <= 4'h0;
    tk(3);
    chk("off", hs, 8'h0f);
    chk("hold", {4'h0, he, hso}, 8'h0c);
    @(posedge clk_i) pin <= 4'hf;
    {ea, eb} <= 2'h3;
    tk(3);
    @(posedge clk_i) pin <= 4'h0;
    tk(3);
    chk("set", hs, 8'hff);
    chk("irq", {7'h0, irq}, 8'h01);
    @(posedge clk_i) go <= 1'b1;
    tk(3);
    chk("uninit", vec, 8'h0f);
    chk("ack", {6'h0, xa, oe}, 8'h03);
    chk("keep", hs, 8'hff);
    @(posedge clk_i) go <= 1'b0;
    vw <= 1'b1;
    @(posedge clk_i) vw <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i) go <= 1'b1;
      tk(3);
      chk("prio", vec, {6'h2a, i[1:0]});
      @(posedge clk_i) go <= 1'b0;
      wr <= 1'b1;
      md <= 8'h01 << i;
      @(posedge clk_i) wr <= 1'b0;
      tk(2);
      chk("clear", hs, 8'hf0 << (i + 1) | 8'h0f);
    end
    @(posedge clk_i) go <= 1'b1;
    tk(3);
    chk("ignored", {5'h0, irq, xa, oe}, 8'h00);
    @(posedge clk_i) pin <= 4'hf;
    tk(3);
    @(posedge clk_i) pin <= 4'h0;
    {fn, asc, svc} <= {IRQ_AUTO, 2'h1, 4'h1};
    tk(3);
    chk("dma tie", {7'h0, irq}, 8'h00);
    @(posedge clk_i) svc <= 4'hf;
    tk(3);
    chk("auto", {6'h0, xa, oe}, 8'h02);
    @(posedge clk_i) fn <= IRQ_VEC;
    tk(3);
    chk("skip", vec, {6'h2a, 2'h1});
    @(posedge clk_i) go <= 1'b0;
    sen <= 4'hf;
    tk(3);
    chk("sense", {4'h0, hs.level}, 8'h00);
    @(posedge clk_i) sen <= 4'h0;
    pa <= 8'ha5;
    pin <= 4'hf;
    tk(3);
    chk("alt", {alta[3:0], altb[3:0]}, 8'h5a);
    @(posedge clk_i) dc <= 1'b1;
    tk(3);
    dl(1'b1);
    dl(1'b0);
    give_verdict();
  end
endmodule : port_service_request_logic_tb
`default_nettype wire
